// ==== tws_map.svh ====
// Register addresses, field positions, reset values and divider counts
// for the three-wire serial control block.
// Assumes the includer uses the names with a leading backtick.
`ifndef TWS_MAP_SVH
`define TWS_MAP_SVH

`define TWS_RF_CTRL_ADDR 7'h1A
`define TWS_PERIPH_SHIFT_ADDR 7'h01
`define TWS_CTRL_RESET 4'h0
`define TWS_BIT_RUN 3
`define TWS_BIT_FLOAT 2
`define TWS_BIT_SEL_HI 1
`define TWS_BIT_SEL_LO 0
`define TWS_SEL_EXT 2'h0
`define TWS_SEL_DIV16 2'h1
`define TWS_SEL_DIV128 2'h2
`define TWS_SEL_DIV1024 2'h3
`define TWS_HALF_DIV16 10'h007
`define TWS_HALF_DIV128 10'h03F
`define TWS_HALF_DIV1024 10'h1FF
`define TWS_LAST_BIT 3'h7
`define TWS_SHIFT_RESET 8'h00

`endif

// ==== tws_pkg.sv ====
// Types shared by the three-wire serial control block.
// Assumes tws_map.svh holds the numeric constants.
package tws_pkg;

    typedef struct packed {
        logic run;
        logic out_float;
        logic [1:0] clk_sel;
    } tws_ctrl_s;

    typedef enum logic [0:0] {
        TWS_STOPPED,
        TWS_SHIFTING
    } tws_state_e;

endpackage

// ==== tws_buf.sv ====
// Two-entry buffer with valid and ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module tws_buf #(
    parameter int W = 8
) (
    input wire logic clk, // System clock
    input wire logic reset_n, // Synchronous reset
    input wire logic [W-1:0] in_data, // Word to store
    input wire logic in_valid, // Word offered
    output logic in_ready, // Room for a word
    output logic [W-1:0] out_data, // Oldest word
    output logic out_valid, // Oldest word present
    input wire logic out_ready // Drain takes a word
);
    logic [W-1:0] head_q, head_d, tail_q, tail_d;
    logic head_v_q, head_v_d, tail_v_q, tail_v_d;

    always_comb begin
        head_d = head_q;
        tail_d = tail_q;
        head_v_d = head_v_q;
        tail_v_d = tail_v_q;
        if (head_v_q && out_ready) begin
            head_d = tail_q;
            head_v_d = tail_v_q;
            tail_v_d = 1'b0;
        end
        if (in_valid && !tail_v_q) begin
            if (!head_v_d) begin
                head_d = in_data;
                head_v_d = 1'b1;
            end else begin
                tail_d = in_data;
                tail_v_d = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            head_q <= '0;
            tail_q <= '0;
            head_v_q <= 1'b0;
            tail_v_q <= 1'b0;
        end else begin
            head_q <= head_d;
            tail_q <= tail_d;
            head_v_q <= head_v_d;
            tail_v_q <= tail_v_d;
        end
    end

    assign in_ready = !tail_v_q;
    assign out_data = head_q;
    assign out_valid = head_v_q;
endmodule // tws_buf
`default_nettype wire

// ==== tws_serial.sv ====
// Three-wire serial interface: control register, shift register, clocking.
// Assumes clk is the system oscillator fx and the CPU side is synchronous.
`timescale 1ns/1ps
`default_nettype none
`include "tws_map.svh"
module tws_serial (
    input wire logic clk, // System clock fx, 10 MHz
    input wire logic reset_n, // Synchronous reset, active low
    input wire logic [6:0] rf_addr, // Register file address
    input wire logic rf_wr, // Register file write strobe
    input wire logic [3:0] rf_wdata, // Register file write nibble
    output logic [3:0] rf_rdata, // Register file read nibble
    input wire logic [6:0] periph_addr, // Peripheral address
    input wire logic periph_write_instr, // Put strobe
    input wire logic periph_read_instr, // Get strobe
    input wire logic [15:0] cpu_data_buffer, // Data buffer contents
    output logic [15:0] get_data, // Data buffer value after a get
    output logic get_load, // Get result valid pulse
    input wire logic serial_function_enable, // Pins in serial mode
    input wire logic done_clear, // Clear the done request
    output logic serial_done_request, // Transfer-done request flag
    input wire logic sck_i, // Serial clock pin level
    output logic sck_o, // Serial clock pin drive
    output logic sck_oe_n, // Serial clock drive enable, low drives
    output logic so_o, // Data-out pin drive
    output logic so_oe_n, // Data-out drive enable, low drives
    input wire logic si_i, // Data-in pin level
    output logic [7:0] rx_data, // Received byte stream
    output logic rx_valid, // Received byte present
    input wire logic rx_ready // Receiver takes a byte
);
    tws_pkg::tws_ctrl_s ctrl_q, ctrl_d;
    tws_pkg::tws_state_e state_q, state_d;
    logic [7:0] shift_q, shift_d;
    logic [2:0] bit_q, bit_d;
    logic [9:0] div_q, div_d;
    logic sck_q, sck_d, so_q, so_d;
    logic done_q, done_d;
    logic [3:0] rdata_q, rdata_d;
    logic [15:0] get_q, get_d;
    logic get_load_q, get_load_d;
    logic sck_oe_n_q, sck_oe_n_d, so_oe_n_q, so_oe_n_d;
    logic sck_s1_q, sck_s2_q, sck_s3_q, si_s1_q, si_s2_q;
    logic push, buf_ready;
    logic [7:0] push_data;
    logic ctrl_wr, put_hit, get_hit, ext_clk;
    logic fall, rise;

    // Half period of the internal serial clock in fx cycles, minus one
    function automatic logic [9:0] half_count(input logic [1:0] sel);
        unique case (sel)
            `TWS_SEL_DIV16: half_count = `TWS_HALF_DIV16;
            `TWS_SEL_DIV128: half_count = `TWS_HALF_DIV128;
            `TWS_SEL_DIV1024: half_count = `TWS_HALF_DIV1024;
            `TWS_SEL_EXT: half_count = `TWS_HALF_DIV16;
        endcase
    endfunction

    // Pin synchronisers
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sck_s1_q <= 1'b1;
            sck_s2_q <= 1'b1;
            sck_s3_q <= 1'b1;
            si_s1_q <= 1'b0;
            si_s2_q <= 1'b0;
        end else begin
            sck_s1_q <= sck_i;
            sck_s2_q <= sck_s1_q;
            sck_s3_q <= sck_s2_q;
            si_s1_q <= si_i;
            si_s2_q <= si_s1_q;
        end
    end

    assign ctrl_wr = rf_wr && (rf_addr == `TWS_RF_CTRL_ADDR);
    assign put_hit = periph_write_instr
        && (periph_addr == `TWS_PERIPH_SHIFT_ADDR);
    assign get_hit = periph_read_instr
        && (periph_addr == `TWS_PERIPH_SHIFT_ADDR);
    assign ext_clk = (ctrl_q.clk_sel == `TWS_SEL_EXT);

    // Edge strobes; internal edges come from the divider
    always_comb begin
        fall = 1'b0;
        rise = 1'b0;
        if (state_q == tws_pkg::TWS_SHIFTING && buf_ready) begin
            if (ext_clk) begin
                fall = sck_s3_q && !sck_s2_q;
                rise = !sck_s3_q && sck_s2_q;
            end else if (div_q == half_count(ctrl_q.clk_sel)) begin
                fall = sck_q;
                rise = !sck_q;
            end
        end
    end

    always_comb begin
        ctrl_d = ctrl_q;
        state_d = state_q;
        shift_d = shift_q;
        bit_d = bit_q;
        div_d = div_q;
        sck_d = sck_q;
        so_d = so_q;
        done_d = done_q;
        push = 1'b0;
        push_data = shift_q;
        if (done_clear) begin
            done_d = 1'b0;
        end
        if (state_q == tws_pkg::TWS_SHIFTING && buf_ready && !ext_clk) begin
            if (div_q == half_count(ctrl_q.clk_sel)) begin
                div_d = '0;
                sck_d = !sck_q;
            end else begin
                div_d = div_q + 10'h001;
            end
        end
        if (fall) begin
            so_d = shift_q[7];
        end
        if (rise) begin
            shift_d = {shift_q[6:0], si_s2_q};
            bit_d = bit_q + 3'h1;
            if (bit_q == `TWS_LAST_BIT) begin
                state_d = tws_pkg::TWS_STOPPED;
                ctrl_d.run = 1'b0;
                done_d = 1'b1;
                sck_d = 1'b1;
                push = 1'b1;
                push_data = {shift_q[6:0], si_s2_q};
            end
        end
        if (put_hit && state_q == tws_pkg::TWS_STOPPED) begin
            shift_d = cpu_data_buffer[7:0];
        end
        if (ctrl_wr) begin
            ctrl_d.out_float = rf_wdata[`TWS_BIT_FLOAT];
            ctrl_d.clk_sel = {rf_wdata[`TWS_BIT_SEL_HI],
                              rf_wdata[`TWS_BIT_SEL_LO]};
            ctrl_d.run = rf_wdata[`TWS_BIT_RUN];
            div_d = '0;
            sck_d = 1'b1;
            bit_d = '0;
            if (rf_wdata[`TWS_BIT_RUN]) begin
                state_d = tws_pkg::TWS_SHIFTING;
                if (!push) begin
                    done_d = 1'b0;
                end
            end else begin
                state_d = tws_pkg::TWS_STOPPED;
            end
        end
    end

    // Read data, get result and pin enables
    always_comb begin
        rdata_d = '0;
        if (rf_addr == `TWS_RF_CTRL_ADDR) begin
            rdata_d[`TWS_BIT_RUN] = ctrl_q.run;
            rdata_d[`TWS_BIT_FLOAT] = ctrl_q.out_float;
            rdata_d[`TWS_BIT_SEL_HI] = ctrl_q.clk_sel[1];
            rdata_d[`TWS_BIT_SEL_LO] = ctrl_q.clk_sel[0];
        end
        get_d = get_q;
        get_load_d = get_hit;
        if (get_hit) begin
            get_d = {cpu_data_buffer[15:8], shift_q};
        end
        sck_oe_n_d = !(serial_function_enable
            && (ctrl_d.clk_sel != `TWS_SEL_EXT));
        so_oe_n_d = !(serial_function_enable
            && !ctrl_d.out_float);
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ctrl_q <= `TWS_CTRL_RESET;
            state_q <= tws_pkg::TWS_STOPPED;
            shift_q <= `TWS_SHIFT_RESET;
            bit_q <= '0;
            div_q <= '0;
            sck_q <= 1'b1;
            so_q <= 1'b0;
            done_q <= 1'b0;
            rdata_q <= '0;
            get_q <= '0;
            get_load_q <= 1'b0;
            sck_oe_n_q <= 1'b1;
            so_oe_n_q <= 1'b1;
        end else begin
            ctrl_q <= ctrl_d;
            state_q <= state_d;
            shift_q <= shift_d;
            bit_q <= bit_d;
            div_q <= div_d;
            sck_q <= sck_d;
            so_q <= so_d;
            done_q <= done_d;
            rdata_q <= rdata_d;
            get_q <= get_d;
            get_load_q <= get_load_d;
            sck_oe_n_q <= sck_oe_n_d;
            so_oe_n_q <= so_oe_n_d;
        end
    end

    tws_buf #(.W(8)) u_rx_buf (
        .clk(clk),
        .reset_n(reset_n),
        .in_data(push_data),
        .in_valid(push),
        .in_ready(buf_ready),
        .out_data(rx_data),
        .out_valid(rx_valid),
        .out_ready(rx_ready)
    );

    assign rf_rdata = rdata_q;
    assign get_data = get_q;
    assign get_load = get_load_q;
    assign serial_done_request = done_q;
    assign sck_o = sck_q;
    assign sck_oe_n = sck_oe_n_q;
    assign so_o = so_q;
    assign so_oe_n = so_oe_n_q;
endmodule // tws_serial
`default_nettype wire

// ==== tws_serial_asserts.sv ====
// Port checks for the three-wire serial control block.
// Assumes a bind onto tws_serial and one clock domain.
`timescale 1ns/1ps
`default_nettype none
`include "tws_map.svh"
module tws_serial_chk (
    input wire logic clk, // Clock
    input wire logic reset_n, // Reset
    input wire logic [6:0] rf_addr, // Reg address
    input wire logic rf_wr, // Reg write
    input wire logic [3:0] rf_wdata, // Write nibble
    input wire logic [3:0] rf_rdata, // Read nibble
    input wire logic [6:0] periph_addr, // Periph address
    input wire logic periph_read_instr, // Get
    input wire logic [15:0] cpu_data_buffer, // Buffer
    input wire logic [15:0] get_data, // Get value
    input wire logic get_load, // Get valid
    input wire logic serial_function_enable, // Pins on
    input wire logic serial_done_request, // Done
    input wire logic sck_o, // Clock drive
    input wire logic sck_oe_n, // Clock enable
    input wire logic so_o, // Data drive
    input wire logic so_oe_n, // Data enable
    input wire logic [7:0] rx_data, // Byte
    input wire logic rx_valid, // Byte present
    input wire logic rx_ready // Byte taken
);
    logic get_hit;
    assign get_hit = periph_read_instr && periph_addr == `TWS_PERIPH_SHIFT_ADDR;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence s_get;
        get_hit;
    endsequence
    sequence s_run_wr(logic v);
        rf_wr && rf_addr == `TWS_RF_CTRL_ADDR && rf_wdata[`TWS_BIT_RUN] == v;
    endsequence
    a_rd_other: assert property ($past(rf_addr) != `TWS_RF_CTRL_ADDR
        |-> rf_rdata == 4'h0) else $error("read of other address not zero");
    a_get_upper: assert property (s_get |=> get_load
        && get_data[15:8] == $past(cpu_data_buffer[15:8]))
        else $error("get result wrong");
    a_get_only: assert property (!get_hit |=> !get_load)
        else $error("get result without get");
    a_pins_off: assert property (!serial_function_enable [*2]
        |-> sck_oe_n && so_oe_n) else $error("pins driven while disabled");
    a_start_clear: assert property (s_run_wr(1'b1) |-> ##2
        !serial_done_request) else $error("start kept done flag");
    a_abort_idle: assert property (s_run_wr(1'b0) |-> ##2 sck_o [*4])
        else $error("clock still running after stop");
    a_done_idle: assert property ($rose(serial_done_request) |-> sck_o)
        else $error("done while clock low");
    a_so_steady: assert property (!sck_oe_n && !sck_o && !$past(sck_o)
        |-> $stable(so_o)) else $error("data out moved while clock low");
    a_half_period: assert property ($rose(sck_o) && !sck_oe_n
        && !$past(rf_wr) && !$past(rf_wr, 2) |-> $past(sck_o, 8) == 1'b0)
        else $error("serial clock half period short");
    a_rx_hold: assert property (rx_valid && !rx_ready |=> rx_valid
        && $stable(rx_data)) else $error("stalled byte lost");
endmodule // tws_serial_chk
bind tws_serial tws_serial_chk tws_serial_chk_i (.clk, .reset_n, .rf_addr,
    .rf_wr, .rf_wdata, .rf_rdata, .periph_addr, .periph_read_instr,
    .cpu_data_buffer, .get_data, .get_load, .serial_function_enable,
    .serial_done_request, .sck_o, .sck_oe_n, .so_o, .so_oe_n, .rx_data,
    .rx_valid, .rx_ready);
`default_nettype wire

// ==== tws_far.sv ====
// Behavioural far-side serial device on the three lines.
// Assumes the bench resolves the clock and data lines.
`timescale 1ns/1ps
`default_nettype none
module tws_far (
    input wire logic sck, // Clock line
    input wire logic so, // Line from block
    input wire logic [7:0] tx_byte, // Byte to send
    input wire logic restart, // Frame begins on fall
    input wire logic ext_go, // Eight external clocks
    output logic si, // Line to block
    output logic ext_sck, // External clock
    output logic [7:0] got // Byte received
);
    logic [7:0] sh;
    initial begin
        {ext_sck, si, got, sh} = {1'b1, 1'b0, 16'h0000};
    end
    always @(negedge restart) sh = tx_byte;
    always @(negedge sck) begin
        si = sh[7];
        sh = {sh[6:0], 1'b0};
    end
    always @(posedge sck) got = {got[6:0], so};
    always @(posedge ext_go) begin // Clock idles high between frames
        repeat (8) begin
            #4000 ext_sck = 1'b0;
            #4000 ext_sck = 1'b1;
        end
    end
endmodule // tws_far
`default_nettype wire

// ==== testbench.sv ====
// Self-checking bench: block, far device and port checker.
// Assumes the design, tws_far and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk, reset_n, rf_wr, periph_write_instr, periph_read_instr;
    logic done_clear, ext_go, restart, rx_ready, serial_function_enable;
    logic get_load, serial_done_request, sck_o, sck_oe_n, so_o, so_oe_n;
    logic rx_valid, ext_sck, si, sck_l, so_l;
    logic [6:0] rf_addr, periph_addr;
    logic [3:0] rf_wdata, rf_rdata;
    logic [15:0] cpu_data_buffer, get_data, w, p, seed;
    logic [7:0] rx_data, got, tx_byte, sh;
    logic [15:0] get_q[$], rx_q[$];
    logic [3:0] stb;
    int fail_count = 0, tests_run = 0;
    localparam int STB_WR = 3;
    localparam int STB_RD = 2;
    localparam int STB_CLR = 1;
    localparam int STB_EXT = 0;
    assign sck_l = sck_oe_n ? ext_sck : sck_o;
    assign so_l = so_oe_n ? 1'b1 : so_o;
    assign {periph_write_instr, periph_read_instr, done_clear, ext_go} = stb;
    tws_serial tws_serial_i (.clk, .reset_n, .rf_addr, .rf_wr, .rf_wdata,
        .rf_rdata, .periph_addr, .periph_write_instr, .periph_read_instr,
        .cpu_data_buffer, .get_data, .get_load, .serial_function_enable,
        .done_clear, .serial_done_request, .sck_i(sck_l), .sck_o, .sck_oe_n,
        .so_o, .so_oe_n, .si_i(si), .rx_data, .rx_valid, .rx_ready);
    tws_far tws_far_i (.sck(sck_l), .so(so_l), .tx_byte, .restart, .ext_go,
        .si, .ext_sck, .got);
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic chk(input string n, input logic [15:0] s, e);
        tests_run++;
        if (s !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    function automatic logic [15:0] xs();
        seed ^= seed << 7;
        seed ^= seed >> 9;
        seed ^= seed << 8;
        return seed;
    endfunction
    task automatic rw(input logic [3:0] d);
        {rf_addr, rf_wdata, rf_wr} <= {7'h1A, d, 1'b1};
        @(posedge clk);
        rf_wr <= 1'b0;
    endtask
    task automatic rd(input logic [6:0] a, input logic [3:0] e);
        rf_addr <= a;
        repeat (2) @(posedge clk);
        chk("rf_rdata", rf_rdata, e);
    endtask
    // One-cycle strobe on the line selected by k
    task automatic pulse(input int k);
        stb[k] <= 1'b1;
        @(posedge clk);
        stb[k] <= 1'b0;
    endtask
    task automatic pg(input logic [6:0] a);
        w = xs();
        if (a == 7'h01) sh = w[7:0];
        {cpu_data_buffer, periph_addr} <= {w, a};
        pulse(STB_WR);
        periph_addr <= 7'h01;
        get_q.push_back({w[15:8], sh});
        pulse(STB_RD);
    endtask
    task automatic xfer(input logic [3:0] c, input logic keep);
        p = xs();
        {tx_byte, restart} <= {p[7:0], 1'b1};
        pg(7'h01);
        restart <= 1'b0;
        if (keep) rx_q.push_back({8'h00, p[7:0]});
        if (keep) sh = p[7:0];
        rw(c);
        repeat (2) @(posedge clk);
        chk("done", serial_done_request, 1'b0);
    endtask
    // Waits for the done flag; e above zero is the expected cycle count
    task automatic wait_done(input int e);
        int n;
        n = 0;
        while (serial_done_request !== 1'b1 && n < 20000) begin
            @(posedge clk);
            n++;
        end
        chk("done", serial_done_request, 1'b1);
        if (e > 0) begin
            chk("cycles", n[15:0], e[15:0]);
        end
    endtask
    always @(posedge clk) begin
        if (get_load === 1'b1)
            chk("get_data", get_data, get_q.pop_front());
        if (rx_valid === 1'b1 && rx_ready === 1'b1)
            chk("rx_data", {8'h00, rx_data}, rx_q.pop_front());
    end
    initial begin
        #3000000;
        chk("watchdog", 16'h0001, 16'h0000);
        give_verdict();
    end
    initial begin
        {seed, sh, tx_byte, cpu_data_buffer} = {16'h20CE, 32'h00000000};
        {reset_n, rf_wr, stb} = 6'h00;
        {restart, rx_ready} = 2'h0;
        {serial_function_enable, rf_addr, periph_addr, rf_wdata} = 19'h40010;
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        rd(7'h1A, 4'h0);
        rw(4'h7);
        rd(7'h1A, 4'h7);
        rd(7'h1B, 4'h0);
        pg(7'h01);
        pg(7'h02);
        repeat (40) @(posedge clk);
        chk("idle", {sck_o, serial_done_request}, 2'h2);
        for (int i = 3; i > 0; i--) begin
            xfer({2'b10, i[1:0]}, 1'b1);
            chk("so_oe_n", so_oe_n, 1'b0);
            if (i == 1) begin
                repeat (300) @(posedge clk);
                rd(7'h1A, 4'h9);
                rx_ready <= 1'b1;
            end
            wait_done(i == 1 ? 0 : (1 << (3 * i + 4)) - 1);
            rd(7'h1A, {2'b00, i[1:0]});
            chk("far_got", got, w[7:0]);
        end
        pg(7'h02);
        xfer(4'h9, 1'b0);
        repeat (40) @(posedge clk);
        rw(4'h1);
        rd(7'h1A, 4'h1);
        chk("stop", {sck_o, serial_done_request}, 2'h2);
        xfer(4'h9, 1'b1);
        wait_done(127);
        chk("far_got", got, w[7:0]);
        pulse(STB_CLR);
        rw(4'h4);
        pulse(STB_EXT);
        repeat (700) @(posedge clk);
        chk("ext_idle", serial_done_request, 1'b0);
        xfer(4'hC, 1'b1);
        chk("so_oe_n", so_oe_n, 1'b1);
        pulse(STB_EXT);
        wait_done(0);
        rw(4'h3);
        repeat (2) @(posedge clk);
        chk("oe_on", {sck_oe_n, so_oe_n}, 2'h0);
        serial_function_enable <= 1'b0;
        repeat (3) @(posedge clk);
        chk("oe_off", {sck_oe_n, so_oe_n}, 2'h3);
        repeat (10) @(posedge clk);
        chk("rx_left", 16'(rx_q.size()), 16'h0000);
        chk("get_left", 16'(get_q.size()), 16'h0000);
        give_verdict();
    end
endmodule // testbench
`default_nettype wire
